// ---- hw/link_param_monitor.sv ----
// Module: link parameter register bank with per-lane error counters over Wishbone
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Saturating error tally, one per lane and error kind
// ----------------------------------------------------------------
module error_tally
  import link_param_pkg::*;
#(
  parameter int unsigned WIDTH = CNT_WIDTH
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_reset,
  input  wire logic             i_event,
  output logic [WIDTH-1:0]      o_count
);

  typedef struct packed {
    logic [WIDTH-1:0] count;
  } tally_state_type;

  tally_state_type state_q;
  tally_state_type state_d;

  // Saturates so a flood cannot wrap back below the threshold
  always_comb begin
    state_d = state_q;
    if (i_event && !(&state_q.count)) begin
      state_d.count = state_q.count + 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_count = state_q.count;

endmodule : error_tally

// ----------------------------------------------------------------
// Per-lane threshold flag and sticky interrupt status
// ----------------------------------------------------------------
module fault_flag_cell
  import link_param_pkg::*;
#(
  parameter int unsigned WIDTH = CNT_WIDTH
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_reset,
  input  wire logic [WIDTH-1:0] i_count,
  input  wire logic [WIDTH-1:0] i_threshold,
  input  wire logic             i_clear,
  output logic                  o_flag,
  output logic                  o_status,
  output logic                  o_status_next
);

  typedef struct packed {
    logic flag;
    logic status;
  } flag_state_type;

  flag_state_type state_q;
  flag_state_type state_d;
  logic           reached;

  // Status takes the rising edge only, so a standing fault cannot refire after a clear
  always_comb begin
    reached        = (i_count >= i_threshold);
    state_d.flag   = reached;
    // Set wins when the edge and a clear land in the same cycle
    state_d.status = (state_q.status && !i_clear) || (reached && !state_q.flag);
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_flag        = state_q.flag;
  assign o_status      = state_q.status;
  assign o_status_next = state_d.status;

endmodule : fault_flag_cell

// ----------------------------------------------------------------
// Register bank top
// ----------------------------------------------------------------
module link_param_monitor
  import link_param_pkg::*;
(
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_reset,
  input  wire logic                 i_wb_cyc,
  input  wire logic                 i_wb_stb,
  input  wire logic                 i_wb_we,
  input  wire logic [ADDR_WIDTH-1:0] i_wb_adr,
  input  wire logic [31:0]          i_wb_dat,
  input  wire logic [3:0]           i_wb_sel,
  input  wire lane_error_type       i_lane_errors,
  output logic                      o_wb_ack,
  output logic [31:0]               o_wb_dat,
  output logic [NUM_LANES-1:0]      o_lane_align_enable,
  output logic [2:0]                o_subclass_version,
  output logic                      o_irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                 ack;
    logic [7:0]           rdata;
    logic [7:0]           conv_per_link;
    logic [7:0]           ctrl_res;
    logic [7:0]           subclass_np;
    logic [7:0]           version_s;
    logic [7:0]           density_cf;
    logic [7:0]           spare_one;
    logic [7:0]           spare_two;
    logic [7:0]           check_value;
    logic [2:0]           lane_pick;
    logic [1:0]           type_pick;
    logic [7:0]           align_enable;
    logic [7:0]           threshold;
    logic [NUM_LANES-1:0] irq_enable;
    logic                 irq;
  } state_type;

  state_type state_q;
  state_type state_d;

  // Counters and flags live in per-lane cells, each with its own packed state
  logic [CNT_WIDTH-1:0] disparity_fault_tally      [NUM_LANES];
  logic [CNT_WIDTH-1:0] invalid_symbol_tally       [NUM_LANES];
  logic [CNT_WIDTH-1:0] stray_control_symbol_tally [NUM_LANES];
  logic [NUM_LANES-1:0] disparity_fault_flags;
  logic [NUM_LANES-1:0] irq_status;
  logic [NUM_LANES-1:0] irq_status_next;
  logic [NUM_LANES-1:0] irq_clear;

  logic                  access;
  logic                  wr;
  logic [11:0]           idx;
  logic [7:0]            wdata;
  logic [7:0]            selected_error_count;

  // Only byte lane 0 carries data; one request acks in one cycle
  assign access = i_wb_cyc && i_wb_stb && !state_q.ack;
  assign wr     = access && i_wb_we && i_wb_sel[0];
  assign idx    = i_wb_adr[ADDR_WIDTH-1:2];
  assign wdata  = i_wb_dat[7:0];

  // Write-one-to-clear strobe for the sticky status bits
  assign irq_clear = (wr && idx == IDX_IRQ_CLEAR) ? wdata[NUM_LANES-1:0] : '0;

  // ----------------------------------------------------------------
  // Per-lane error tallies and fault flags
  // ----------------------------------------------------------------
  for (genvar l = 0; l < NUM_LANES; l++) begin : g_lane
    error_tally #(
      .WIDTH (CNT_WIDTH)
    ) u_disparity (
      .i_sys_clk (i_sys_clk),
      .i_reset   (i_reset),
      .i_event   (i_lane_errors.disparity[l]),
      .o_count   (disparity_fault_tally[l])
    );

    error_tally #(
      .WIDTH (CNT_WIDTH)
    ) u_invalid (
      .i_sys_clk (i_sys_clk),
      .i_reset   (i_reset),
      .i_event   (i_lane_errors.invalid_symbol[l]),
      .o_count   (invalid_symbol_tally[l])
    );

    error_tally #(
      .WIDTH (CNT_WIDTH)
    ) u_stray (
      .i_sys_clk (i_sys_clk),
      .i_reset   (i_reset),
      .i_event   (i_lane_errors.stray_control[l]),
      .o_count   (stray_control_symbol_tally[l])
    );

    fault_flag_cell #(
      .WIDTH (CNT_WIDTH)
    ) u_flag (
      .i_sys_clk     (i_sys_clk),
      .i_reset       (i_reset),
      .i_count       (disparity_fault_tally[l]),
      .i_threshold   (state_q.threshold),
      .i_clear       (irq_clear[l]),
      .o_flag        (disparity_fault_flags[l]),
      .o_status      (irq_status[l]),
      .o_status_next (irq_status_next[l])
    );
  end

  // ----------------------------------------------------------------
  // Monitor readback mux
  // ----------------------------------------------------------------
  always_comb begin
    case (state_q.type_pick)
      PICK_DISPARITY: selected_error_count = disparity_fault_tally[state_q.lane_pick];
      PICK_INVALID:   selected_error_count = invalid_symbol_tally[state_q.lane_pick];
      PICK_STRAY:     selected_error_count = stray_control_symbol_tally[state_q.lane_pick];
      default:        selected_error_count = BYTE_ZERO;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    state_d.ack = access;

    // Write decode
    if (wr) begin
      case (idx)
        IDX_CONV_PER_LINK: state_d.conv_per_link = wdata;
        IDX_CTRL_RES:      state_d.ctrl_res = wdata & MASK_CTRL_RES;
        IDX_SUBCLASS_NP:   state_d.subclass_np = wdata;
        IDX_VERSION_S: begin
          // Samples field only takes 0 or 1; other values leave it unchanged
          state_d.version_s[SUBCLASS_MSB:SUBCLASS_LSB] = wdata[SUBCLASS_MSB:SUBCLASS_LSB];
          if (wdata[SAMPLES_MSB:SAMPLES_LSB] <= SAMPLES_MAX) begin
            state_d.version_s[SAMPLES_MSB:SAMPLES_LSB] = wdata[SAMPLES_MSB:SAMPLES_LSB];
          end
        end
        IDX_DENSITY_CF:    state_d.density_cf = wdata & MASK_DENSITY_CF;
        IDX_SPARE_ONE:     state_d.spare_one = wdata;
        IDX_SPARE_TWO:     state_d.spare_two = wdata;
        IDX_CHECK_VALUE:   state_d.check_value = wdata;
        IDX_ERR_MONITOR: begin
          state_d.lane_pick = wdata[LANE_PICK_MSB:LANE_PICK_LSB];
          state_d.type_pick = wdata[TYPE_PICK_MSB:TYPE_PICK_LSB];
        end
        IDX_ALIGN_ENABLE:  state_d.align_enable = wdata;
        IDX_THRESHOLD:     state_d.threshold = wdata;
        IDX_IRQ_ENABLE:    state_d.irq_enable = wdata;
        IDX_IRQ_CLEAR:     ;  // Strobe decoded beside the lane cells
        default: ;
      endcase
    end

    // Level interrupt follows next status, so it lines up with the status bits
    state_d.irq = |(irq_status_next & state_d.irq_enable);

    // Read decode; unmapped addresses read zero
    case (idx)
      IDX_CONV_PER_LINK: state_d.rdata = state_q.conv_per_link;
      IDX_CTRL_RES:      state_d.rdata = state_q.ctrl_res;
      IDX_SUBCLASS_NP:   state_d.rdata = state_q.subclass_np;
      IDX_VERSION_S:     state_d.rdata = state_q.version_s;
      IDX_DENSITY_CF:    state_d.rdata = state_q.density_cf;
      IDX_SPARE_ONE:     state_d.rdata = state_q.spare_one;
      IDX_SPARE_TWO:     state_d.rdata = state_q.spare_two;
      IDX_CHECK_VALUE:   state_d.rdata = state_q.check_value;
      IDX_ERR_MONITOR:   state_d.rdata = selected_error_count;
      IDX_ALIGN_ENABLE:  state_d.rdata = state_q.align_enable;
      IDX_FAULT_FLAGS:   state_d.rdata = disparity_fault_flags;
      IDX_THRESHOLD:     state_d.rdata = state_q.threshold;
      IDX_IRQ_STATUS:    state_d.rdata = irq_status;
      IDX_IRQ_ENABLE:    state_d.rdata = state_q.irq_enable;
      default:           state_d.rdata = BYTE_ZERO;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state_q               <= '0;
      state_q.conv_per_link <= RST_CONV_PER_LINK;
      state_q.ctrl_res      <= RST_CTRL_RES;
      state_q.subclass_np   <= RST_SUBCLASS_NP;
      state_q.version_s     <= RST_VERSION_S;
      state_q.density_cf    <= RST_DENSITY_CF;
      state_q.spare_one     <= RST_SPARE;
      state_q.spare_two     <= RST_SPARE;
      state_q.check_value   <= RST_CHECK_VALUE;
      state_q.align_enable  <= RST_ALIGN_ENABLE;
      state_q.threshold     <= RST_THRESHOLD;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_wb_ack            = state_q.ack;
  assign o_wb_dat            = {24'h000000, state_q.rdata};
  assign o_lane_align_enable = state_q.align_enable;
  assign o_subclass_version  = state_q.subclass_np[SUBCLASS_MSB:SUBCLASS_LSB];
  assign o_irq               = state_q.irq;

endmodule : link_param_monitor

// ---- hw/link_param_pkg.sv ----
// Package: register map, field layouts and carriers for the link parameter and error monitor
package link_param_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned NUM_LANES  = 8;
  localparam int unsigned CNT_WIDTH  = 8;
  localparam int unsigned ADDR_WIDTH = 14;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [11:0] IDX_CONV_PER_LINK  = 12'h456;
  localparam logic [11:0] IDX_CTRL_RES       = 12'h457;
  localparam logic [11:0] IDX_SUBCLASS_NP    = 12'h458;
  localparam logic [11:0] IDX_VERSION_S      = 12'h459;
  localparam logic [11:0] IDX_DENSITY_CF     = 12'h45a;
  localparam logic [11:0] IDX_SPARE_ONE      = 12'h45b;
  localparam logic [11:0] IDX_SPARE_TWO      = 12'h45c;
  localparam logic [11:0] IDX_CHECK_VALUE    = 12'h45d;
  localparam logic [11:0] IDX_ERR_MONITOR    = 12'h46b;
  localparam logic [11:0] IDX_ALIGN_ENABLE   = 12'h46c;
  localparam logic [11:0] IDX_FAULT_FLAGS    = 12'h46d;
  localparam logic [11:0] IDX_THRESHOLD      = 12'h47c;
  localparam logic [11:0] IDX_IRQ_STATUS     = 12'h480;
  localparam logic [11:0] IDX_IRQ_ENABLE     = 12'h481;
  localparam logic [11:0] IDX_IRQ_CLEAR      = 12'h482;

  // ----------------------------------------------------------------
  // Write masks (reserved bits stay zero)
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_FULL       = 8'hff;
  localparam logic [7:0] MASK_CTRL_RES   = 8'hdf;
  localparam logic [7:0] MASK_DENSITY_CF = 8'h9f;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CONV_PER_LINK = 8'h01;
  localparam logic [7:0] RST_CTRL_RES      = 8'h0f;
  localparam logic [7:0] RST_SUBCLASS_NP   = 8'h2f;
  localparam logic [7:0] RST_VERSION_S     = 8'h20;
  localparam logic [7:0] RST_DENSITY_CF    = 8'h80;
  localparam logic [7:0] RST_SPARE         = 8'h00;
  localparam logic [7:0] RST_CHECK_VALUE   = 8'h45;
  localparam logic [7:0] RST_ALIGN_ENABLE  = 8'h0f;
  localparam logic [7:0] RST_THRESHOLD     = 8'hff;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned LANE_PICK_LSB = 4;
  localparam int unsigned LANE_PICK_MSB = 6;
  localparam int unsigned TYPE_PICK_LSB = 0;
  localparam int unsigned TYPE_PICK_MSB = 1;
  localparam int unsigned SUBCLASS_LSB  = 5;
  localparam int unsigned SUBCLASS_MSB  = 7;
  localparam int unsigned SAMPLES_LSB   = 0;
  localparam int unsigned SAMPLES_MSB   = 4;
  localparam logic [4:0]  SAMPLES_MAX   = 5'h01;

  // Error counter kinds
  localparam logic [1:0] PICK_DISPARITY = 2'h0;
  localparam logic [1:0] PICK_INVALID   = 2'h1;
  localparam logic [1:0] PICK_STRAY     = 2'h2;

  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NUM_LANES-1:0] disparity;
    logic [NUM_LANES-1:0] invalid_symbol;
    logic [NUM_LANES-1:0] stray_control;
  } lane_error_type;

  typedef struct packed {
    logic       ack;
    logic [7:0] data;
  } bus_reply_type;

endpackage : link_param_pkg

// ---- testbench/lane_error_source.sv ----
// Partner: link transmitter side, injecting per-lane decode errors
`timescale 1ns/1ps
module lane_error_source
  import link_param_pkg::*;
(
  input  wire logic     i_sys_clk,
  output lane_error_type o_errors
);
  initial o_errors = '0;
  // One-cycle pulses with a gap, so every error is a separate event
  task automatic burst(input int kind, input int lane, input int n);
    repeat (n) begin
      @(posedge i_sys_clk);
      o_errors[(2 - kind) * NUM_LANES + lane] <= 1'b1;
      @(posedge i_sys_clk);
      o_errors <= '0;
    end
  endtask : burst
endmodule : lane_error_source

// ---- testbench/link_param_monitor_props.sv ----
// Checker: bus timing and register side effects of the link parameter monitor
`timescale 1ns/1ps
module link_param_monitor_props
  import link_param_pkg::*;
(
  input wire logic                  i_sys_clk,
  input wire logic                  i_reset,
  input wire logic                  i_wb_cyc,
  input wire logic                  i_wb_stb,
  input wire logic                  i_wb_we,
  input wire logic [ADDR_WIDTH-1:0] i_wb_adr,
  input wire logic [31:0]           i_wb_dat,
  input wire logic [3:0]            i_wb_sel,
  input wire lane_error_type        i_lane_errors,
  input wire logic                  o_wb_ack,
  input wire logic [31:0]           o_wb_dat,
  input wire logic [NUM_LANES-1:0]  o_lane_align_enable,
  input wire logic [2:0]            o_subclass_version,
  input wire logic                  o_irq
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  // Take only counts when ack is low, mirroring the slave's own refusal of re-takes
  wire logic        take  = i_wb_cyc && i_wb_stb && !o_wb_ack;
  wire logic [11:0] idx   = i_wb_adr[13:2];
  wire logic        wtake = take && i_wb_we && i_wb_sel[0];
  ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack held too long");
  ack_timely_a: assert property (take |=> o_wb_ack) else $error("ack missing");
  ack_cause_a: assert property (!take |=> !o_wb_ack) else $error("ack without request");
  upper_zero_a: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h0) else $error("upper data set");
  align_write_a: assert property (wtake && idx == IDX_ALIGN_ENABLE |=>
    o_lane_align_enable == $past(i_wb_dat[7:0])) else $error("deskew not written");
  align_hold_a: assert property (!(wtake && idx == IDX_ALIGN_ENABLE) |=>
    $stable(o_lane_align_enable)) else $error("deskew changed");
  subclass_write_a: assert property (wtake && idx == IDX_SUBCLASS_NP |=>
    o_subclass_version == $past(i_wb_dat[7:5])) else $error("subclass not written");
  reserved_zero_a: assert property (take && !i_wb_we && idx == IDX_CTRL_RES |=>
    o_wb_dat[5] == 1'b0) else $error("reserved bit set");
  cover property (wtake && idx == IDX_ERR_MONITOR);
  cover property ($rose(o_irq));
  cover property (take && !i_wb_we && idx == IDX_FAULT_FLAGS);
endmodule : link_param_monitor_props

bind link_param_monitor link_param_monitor_props props (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
  .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_dat(i_wb_dat),
  .i_wb_sel(i_wb_sel), .i_lane_errors(i_lane_errors), .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat),
  .o_lane_align_enable(o_lane_align_enable), .o_subclass_version(o_subclass_version), .o_irq(o_irq));

// ---- testbench/link_param_monitor_tb.sv ----
// Testbench: register bank, error monitor, fault flags and interrupt
`timescale 1ns/1ps
module link_param_monitor_tb
  import link_param_pkg::*;
;
  logic                  clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq;
  logic [ADDR_WIDTH-1:0] adr = '0;
  logic [31:0]           wdat = '0, rdat;
  logic [3:0]            sel = 4'h0;
  logic [7:0]            align;
  logic [2:0]            subv;
  lane_error_type        errs;
  int                    err_total = 0, samples_checked = 0;
  always #50 clk = ~clk;
  lane_error_source src (.i_sys_clk(clk), .o_errors(errs));
  link_param_monitor uut (.i_sys_clk(clk), .i_reset(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .i_lane_errors(errs), .o_wb_ack(ack),
    .o_wb_dat(rdat), .o_lane_align_enable(align), .o_subclass_version(subv), .o_irq(irq));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [11:0] i, input logic [7:0] d, input logic [3:0] s,
                    output logic [31:0] r);
    int n;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {i, 2'b00}; wdat <= {24'h0, d}; sel <= s;
    n = 0;
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 40);
    r = rdat;
    if (n >= 40) begin err_total++; end_sim(); end
    cyc <= 1'b0; stb <= 1'b0;
  endtask : wb
  task automatic wr(input logic [11:0] i, input logic [7:0] d);
    logic [31:0] r;
    wb(1'b1, i, d, 4'h1, r);
  endtask : wr
  task automatic rd(input logic [11:0] i, output logic [31:0] r);
    wb(1'b0, i, 8'h00, 4'h1, r);
  endtask : rd
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic reset_values();
    logic [11:0] ix [12] = '{12'h456, 12'h457, 12'h458, 12'h459, 12'h45a, 12'h45b, 12'h45c, 12'h45d,
                             12'h46b, 12'h46c, 12'h46d, 12'h47c};
    logic [7:0]  ex [12] = '{8'h01, 8'h0f, 8'h2f, 8'h20, 8'h80, 8'h00, 8'h00, 8'h45,
                             8'h00, 8'h0f, 8'h00, 8'hff};
    logic [31:0] r;
    chk({16'h0, align, 5'h0, subv}, {16'h0, 8'h0f, 8'h01});
    foreach (ix[k]) begin rd(ix[k], r); chk(r, {24'h0, ex[k]}); end
  endtask : reset_values
  task automatic param_writes();
    logic [31:0] r;
    wr(12'h456, 8'h00); rd(12'h456, r); chk(r, 32'h00);
    wr(12'h457, 8'hff); rd(12'h457, r); chk(r, 32'hdf);
    wr(12'h457, 8'h0f); wr(12'h45a, 8'hff); rd(12'h45a, r); chk(r, 32'h9f);
    wr(12'h45a, 8'h80); wr(12'h458, 8'h0f); chk(subv, 32'h0);
    wr(12'h459, 8'h21); wr(12'h459, 8'h23); rd(12'h459, r); chk(r, 32'h21);
    wr(12'h45b, 8'ha5); wb(1'b1, 12'h45b, 8'h3c, 4'he, r); rd(12'h45b, r); chk(r, 32'ha5);
    wr(12'h450, 8'h77); rd(12'h450, r); chk(r, 32'h00);
    wr(12'h46c, 8'ha5); chk(align, 32'ha5);
  endtask : param_writes
  task automatic error_monitor();
    logic [31:0] r;
    logic [7:0]  ex [4] = '{8'h03, 8'h05, 8'h00, 8'h00};
    src.burst(0, 7, 3); src.burst(1, 7, 5); src.burst(2, 0, 2);
    for (int t = 0; t < 4; t++) begin
      wr(12'h46b, {1'b0, 3'd7, 2'b00, t[1:0]}); rd(12'h46b, r); chk(r, {24'h0, ex[t]});
    end
    wr(12'h46b, 8'h02); rd(12'h46b, r); chk(r, 32'h02);
  endtask : error_monitor
  task automatic fault_irq();
    logic [31:0] r;
    wr(12'h47c, 8'h04); wr(12'h481, 8'h80); rd(12'h46d, r); chk(r, 32'h00);
    src.burst(0, 7, 1); rd(12'h46d, r); chk(r, 32'h80);
    rd(12'h480, r); chk({r[31:1], irq}, 32'h81);
    wr(12'h481, 8'h00); rd(12'h480, r); chk({r[31:1], irq}, 32'h80);
    wr(12'h481, 8'h80); wr(12'h482, 8'h80); rd(12'h480, r); chk({r[31:1], irq}, 32'h00);
  endtask : fault_irq
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    reset_values();
    param_writes();
    error_monitor();
    fault_irq();
    end_sim();
  end
endmodule : link_param_monitor_tb
